//--- verilog/dsa_pkg.sv
// package: constants and carriers for the drive status assembler
package dsa_pkg;
   // ---------------------------------------------------------------
   // register bus offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_STATUS_IN = 4'h0;
   localparam logic [3:0] ADDR_INPUT_CTL = 4'h1;
   localparam logic [3:0] ADDR_FILE_CTL = 4'h2;
   localparam logic [3:0] ADDR_BUS_OUT = 4'h3;
   localparam logic [3:0] ADDR_ORIENT_LO = 4'h4;
   localparam logic [3:0] ADDR_ORIENT_HI = 4'h5;
   localparam logic [3:0] ADDR_BRANCH = 4'h6;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int ICR_BR_LO = 0;
   localparam int ICR_TAG_GATE = 2;
   localparam int ICR_TAG_LO = 4;
   localparam int FCR_LOCK_REF = 0;
   localparam int FCR_LOCK_DATA = 1;
   localparam int FCR_SYNC = 6;
   localparam int FCR_UNIT_SEL = 7;
   localparam int BOR_SAVE_SECTOR = 7;
   // ---------------------------------------------------------------
   // reset values and codes
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] TAG_OPERATE = 4'hC;
   localparam logic [15:0] ORIENT_PRESET = 16'h0010;
   localparam logic [15:0] ORIENT_HIT = 16'h1A3F;
   localparam logic [15:0] ORIENT_ZERO = 16'h0000;
   localparam logic [2:0] SERVO_MISS_MAX = 3'h0;
   localparam logic [3:0] SERVO_MISS_LIMIT = 4'hE;
   // servo cell time 1.24 us; a miss counts once per missed cell
   localparam int SERVO_CELL_NS = 1240;
   localparam int CLK_NS = 10;
   localparam int SERVO_CELL_CYC = (SERVO_CELL_NS + CLK_NS - 1) / CLK_NS;
   // ---------------------------------------------------------------
   // select codes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      SEL_FAR_LO = 4'h0, SEL_FAR_HI = 4'h1, SEL_PHYS = 4'h2, SEL_NONE3 = 4'h3,
      SEL_CHAN = 4'h4, SEL_RW = 4'h5, SEL_ECC = 4'h6, SEL_DRIVE = 4'h7,
      SEL_HARD1 = 4'h8, SEL_HARD2 = 4'h9, SEL_ADDR = 4'hA, SEL_CTLSW = 4'hB,
      SEL_DATASW = 4'hC, SEL_CHPTR = 4'hD, SEL_NONEE = 4'hE, SEL_CASS = 4'hF
   } dsa_sel_e;
   // status inputs gathered from the controller
   typedef struct packed {
      logic [11:0] fault_address;
      logic phys_addr;
      logic [4:0] chan_err;
      logic [5:0] rw_err;
      logic [3:0] ecc_err;
      logic [6:0] hard1;
      logic [1:0] hard2;
      logic [1:0] log_addr;
      logic chan_sel;
      logic [1:0] chan_disable_switch;
      logic [3:0] func_sw;
      logic single_cu;
      logic mch_inactive;
      logic exec_rpt;
      logic ce_position;
      logic [7:0] data_sw;
      logic switched_b;
      logic [4:0] cassette;
   } dsa_stat_s;
   // drive side inputs
   typedef struct packed {
      logic [7:0] bus_in;
      logic bus_in_par;
      logic [5:0] drive_sel;
      logic tag_valid;
      logic device_check;
      logic servo_clk;
   } dsa_drv_s;
endpackage : dsa_pkg

//--- verilog/dsa_top.sv
// design: status input assembler and orientation counter
`timescale 1ns/1ps
`default_nettype none
// How it works
// - tag gate set: drive bus-in goes into status input register
// - tag gate clear: tag field selects internal status group
// - status register loads every clock-D; no result bus path
// - code 4: buffer parity and channel timing faults
// - code 5: write, read, bit ring and compensation checks
// - code 5 bits 5-7: servo miss over 14, 2F frequency, phase
// - code 6: error-correction faults
// - code 7: position, tag invalid, device check, bus-in parity
// - position code bad unless exactly three of six lines active
// - code A: logical address and selected channel disabled
// - code B: switches, indications; bit 7 zero in engineer position
// - code D bit 5 channel B; code C data switches
// - code F: cassette status bits
// - save-sector with operate tag presets counter to 10 hex
// - counter steps once per two bytes during retry
// - both lock bits open the hit window for the branch
// - at 1A3F raise hit and return counter to zero
// - hit repeats each revolution while retry lasts
// - sync bit cancels both lock bits to the oscillator
// - file control bit 7 drives unit select
module dsa_top
   import dsa_pkg::*;
(
   // clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic CE,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // timing
   input wire logic CLOCK_D,
   input wire logic BYTE_PAIR,
   // status groups and drive
   input wire dsa_stat_s STAT,
   input wire dsa_drv_s DRV,
   input wire logic VFO_FREQ_ERR,
   input wire logic VFO_PHASE_ERR,
   // drive outputs
   output logic [3:0] TAG_OUT,
   output logic TAG_GATE,
   output logic [7:0] BUS_OUT,
   output logic UNIT_SELECT,
   output logic GATE_REF,
   output logic GATE_DATA,
   // branch
   output logic HIT,
   output logic COMPARE_BRANCH
);
   // ---------------------------------------------------------------
   // registers and synchronisers
   // ---------------------------------------------------------------
   logic [7:0] icr_q;
   logic [7:0] fcr_q;
   logic [7:0] bor_q;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [15:0] orient_q;
   logic hit_q;
   logic [7:0] rdata_q;
   dsa_drv_s drv_m_q;
   dsa_drv_s drv_s_q;
   logic [2:0] pos_cnt;
   logic pos_bad;
   logic par_bad;
   logic [3:0] miss_q;
   logic [7:0] cell_q;
   logic servo_prev_q;
   logic servo_fail_q;
   logic tag_par_q;
   logic dev_chk_q;
   logic tag_inv_q;
   logic window;
   logic save_pulse;

   // two-flop capture of drive lines
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         drv_m_q <= '0;
         drv_s_q <= '0;
      end else if (CE) begin
         drv_m_q <= DRV;
         drv_s_q <= drv_m_q;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         icr_q <= REG_RESET;
         fcr_q <= REG_RESET;
         bor_q <= REG_RESET;
      end else if (CE && WR) begin
         case (ADDR)
            ADDR_INPUT_CTL: icr_q <= WDATA;
            ADDR_FILE_CTL: fcr_q <= WDATA;
            ADDR_BUS_OUT: bor_q <= WDATA;
            default: ;
         endcase
      end
   end

   // save-sector seen on a bus-out write under operate tag
   assign save_pulse = WR && (ADDR == ADDR_BUS_OUT) && WDATA[BOR_SAVE_SECTOR]
      && icr_q[ICR_TAG_GATE] && (icr_q[ICR_TAG_LO+:4] == TAG_OPERATE);

   // read data, one cycle after strobe
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         rdata_q <= REG_RESET;
      end else if (CE) begin
         if (RD) begin
            case (ADDR)
               ADDR_STATUS_IN: rdata_q <= status_q;
               ADDR_INPUT_CTL: rdata_q <= icr_q;
               ADDR_FILE_CTL: rdata_q <= fcr_q;
               ADDR_BUS_OUT: rdata_q <= bor_q;
               ADDR_ORIENT_LO: rdata_q <= orient_q[7:0];
               ADDR_ORIENT_HI: rdata_q <= orient_q[15:8];
               ADDR_BRANCH: rdata_q <= {6'h00, window, hit_q};
               default: rdata_q <= REG_RESET;
            endcase
         end else begin
            rdata_q <= REG_RESET;
         end
      end
   end

   // ---------------------------------------------------------------
   // drive-side checks
   // ---------------------------------------------------------------
   // position code valid only with exactly three lines active
   always_comb begin
      pos_cnt = 3'h0;
      for (int i = 0; i < 6; i++) begin
         pos_cnt = pos_cnt + {2'h0, drv_s_q.drive_sel[i]};
      end
   end
   assign pos_bad = (pos_cnt != 3'h3);
   assign par_bad = ~(^{drv_s_q.bus_in, drv_s_q.bus_in_par});

   // bus-in parity check during listed tags, sticky until reset, held while gate is clear
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         tag_par_q <= 1'b0;
         tag_inv_q <= 1'b0;
         dev_chk_q <= 1'b0;
      end else if (CE) begin
         if (!icr_q[ICR_TAG_GATE]) begin
            tag_par_q <= tag_par_q;
         end else begin
            case (icr_q[ICR_TAG_LO+:4])
               4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB, 4'hC:
                  tag_par_q <= tag_par_q | par_bad;
               default: ;
            endcase
            tag_inv_q <= tag_inv_q | ~drv_s_q.tag_valid;
            dev_chk_q <= dev_chk_q | drv_s_q.device_check;
         end
      end
   end

   // missing servo clock detector after drive selection
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         servo_prev_q <= 1'b0;
         cell_q <= 8'h00;
         miss_q <= 4'h0;
         servo_fail_q <= 1'b0;
      end else if (CE) begin
         servo_prev_q <= drv_s_q.servo_clk;
         if (!fcr_q[FCR_UNIT_SEL]) begin
            cell_q <= 8'h00;
            miss_q <= 4'h0;
            servo_fail_q <= 1'b0;
         end else if (drv_s_q.servo_clk && !servo_prev_q) begin
            cell_q <= 8'h00;
            miss_q <= 4'h0;
         end else if (cell_q == 8'(SERVO_CELL_CYC - 1)) begin
            cell_q <= 8'h00;
            if (miss_q >= SERVO_MISS_LIMIT) begin
               servo_fail_q <= 1'b1;
            end else begin
               miss_q <= miss_q + 4'h1;
            end
         end else begin
            cell_q <= cell_q + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // status assembler
   // ---------------------------------------------------------------
   always_comb begin
      status_d = 8'h00;
      if (icr_q[ICR_TAG_GATE]) begin
         status_d = drv_s_q.bus_in;
      end else begin
         case (dsa_sel_e'(icr_q[ICR_TAG_LO+:4]))
            SEL_FAR_LO: status_d = {STAT.fault_address[5:0], 2'b00};
            SEL_FAR_HI: status_d = {2'b00, STAT.fault_address[11:6]};
            SEL_PHYS: status_d = {drv_s_q.drive_sel, STAT.phys_addr, 1'b0};
            SEL_CHAN: status_d = {2'b00, STAT.chan_err[4:3],
               STAT.chan_err[2:1], 1'b0, STAT.chan_err[0]};
            SEL_RW: status_d = {VFO_PHASE_ERR, VFO_FREQ_ERR, servo_fail_q,
               STAT.rw_err[3:0], 1'b0};
            SEL_ECC: status_d = {4'h0, STAT.ecc_err};
            SEL_DRIVE: status_d = {3'b000, tag_par_q, 1'b0, dev_chk_q,
               tag_inv_q, pos_bad};
            SEL_HARD1: status_d = {1'b0, STAT.hard1};
            SEL_HARD2: status_d = {6'h00, STAT.hard2};
            SEL_ADDR: status_d = {2'b00,
               STAT.chan_disable_switch[STAT.chan_sel], 3'b000,
               STAT.log_addr};
            SEL_CTLSW: status_d = {~STAT.ce_position, STAT.exec_rpt,
               STAT.mch_inactive, STAT.single_cu, STAT.func_sw};
            SEL_DATASW: status_d = STAT.data_sw;
            SEL_CHPTR: status_d = {2'b00, STAT.switched_b, 5'h00};
            SEL_CASS: status_d = {3'b000, STAT.cassette};
            default: status_d = 8'h00;
         endcase
      end
   end

   // status register loads on clock-D only
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         status_q <= REG_RESET;
      end else if (CE && CLOCK_D) begin
         status_q <= status_d;
      end
   end

   // ---------------------------------------------------------------
   // orientation counter
   // ---------------------------------------------------------------
   assign window = fcr_q[FCR_LOCK_REF] && fcr_q[FCR_LOCK_DATA];

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         orient_q <= ORIENT_ZERO;
         hit_q <= 1'b0;
      end else if (CE) begin
         hit_q <= 1'b0;
         if (save_pulse) begin
            orient_q <= ORIENT_PRESET;
         end else if (BYTE_PAIR) begin
            if (orient_q == ORIENT_HIT) begin
               orient_q <= ORIENT_ZERO;
               hit_q <= 1'b1;
            end else begin
               orient_q <= orient_q + 16'h0001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // drive outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         TAG_OUT <= 4'h0;
         TAG_GATE <= 1'b0;
         BUS_OUT <= REG_RESET;
         UNIT_SELECT <= 1'b0;
         GATE_REF <= 1'b0;
         GATE_DATA <= 1'b0;
         HIT <= 1'b0;
         COMPARE_BRANCH <= 1'b0;
      end else if (CE) begin
         TAG_OUT <= icr_q[ICR_TAG_LO+:4];
         TAG_GATE <= icr_q[ICR_TAG_GATE];
         BUS_OUT <= bor_q;
         UNIT_SELECT <= fcr_q[FCR_UNIT_SEL];
         GATE_REF <= fcr_q[FCR_LOCK_REF] & ~fcr_q[FCR_SYNC];
         GATE_DATA <= fcr_q[FCR_LOCK_DATA] & ~fcr_q[FCR_SYNC];
         HIT <= hit_q;
         COMPARE_BRANCH <= hit_q & window;
      end
   end

   assign RDATA = rdata_q;
endmodule : dsa_top
`default_nettype wire

//--- bench/dsa_top_assertions.sv
// checker: port assertions for the status assembler
`timescale 1ns/1ps
`default_nettype none
module dsa_top_assertions
   import dsa_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // drive and branch
   input wire logic [3:0] TAG_OUT,
   input wire logic TAG_GATE,
   input wire logic [7:0] BUS_OUT,
   input wire logic UNIT_SELECT,
   input wire logic GATE_REF,
   input wire logic HIT,
   input wire logic COMPARE_BRANCH
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   // write decodes
   wire logic icw = WR && ADDR == ADDR_INPUT_CTL;
   wire logic fcw = WR && ADDR == ADDR_FILE_CTL;
   wire logic bow = WR && ADDR == ADDR_BUS_OUT;
   property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_unit; fcw |-> ##2 UNIT_SELECT == $past(WDATA[FCR_UNIT_SEL], 2); endproperty
   a_unit: assert property (p_unit) else $error("unit select wrong");
   property p_tag; icw |-> ##2 TAG_OUT == $past(WDATA[7:4], 2); endproperty
   a_tag: assert property (p_tag) else $error("tag field wrong");
   property p_gate; icw |-> ##2 TAG_GATE == $past(WDATA[ICR_TAG_GATE], 2); endproperty
   a_gate: assert property (p_gate) else $error("tag gate wrong");
   property p_bus; bow |-> ##2 BUS_OUT == $past(WDATA, 2); endproperty
   a_bus: assert property (p_bus) else $error("bus out wrong");
   property p_ref;
      fcw |-> ##2 GATE_REF == ($past(WDATA[0], 2) && !$past(WDATA[FCR_SYNC], 2));
   endproperty
   a_ref: assert property (p_ref) else $error("reference gate wrong");
   property p_br; COMPARE_BRANCH |-> HIT; endproperty
   a_br: assert property (p_br) else $error("branch without hit");
   property p_hit; HIT |=> !HIT [*8]; endproperty
   a_hit: assert property (p_hit) else $error("hit not single");
endmodule : dsa_top_assertions
bind dsa_top dsa_top_assertions chk_u (.CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TAG_OUT(TAG_OUT), .TAG_GATE(TAG_GATE),
   .BUS_OUT(BUS_OUT), .UNIT_SELECT(UNIT_SELECT), .GATE_REF(GATE_REF), .HIT(HIT),
   .COMPARE_BRANCH(COMPARE_BRANCH));
`default_nettype wire

//--- bench/dsa_drive_model.sv
// model: disk drive answering on tag and bus lines
`timescale 1ns/1ps
`default_nettype none
module dsa_drive_model
   import dsa_pkg::*;
(
   // clock
   input wire logic clk,
   // from controller
   input wire logic [3:0] tag_out,
   input wire logic tag_gate,
   input wire logic [7:0] bus_out,
   input wire logic unit_select,
   input wire logic [7:0] resp,
   input wire logic bad_lines,
   // to controller
   output var dsa_drv_s drv,
   output var logic rec_ready
);
   logic [7:0] last_q = 8'h00;
   logic [7:0] sector_q = 8'h00;
   logic [7:0] saved_q = 8'h00;
   logic [7:0] target_q = 8'h00;
   logic servo_q = 1'b0;
   int cell_q = 0;
   // sector count, save-sector copy, servo cells
   always_ff @(posedge clk) begin
      sector_q <= sector_q + 8'h01;
      if (tag_gate && tag_out == TAG_OPERATE && bus_out[BOR_SAVE_SECTOR]) begin
         saved_q <= sector_q;
      end
      // transmit-sector tag loads the sector to wait for
      if (tag_gate && tag_out == 4'h1) begin
         target_q <= bus_out;
      end
      rec_ready <= (sector_q == target_q);
      // remember what was driven, for the released bus
      if (tag_gate) begin
         last_q <= resp;
      end
      cell_q <= (cell_q >= SERVO_CELL_CYC - 1) ? 0 : cell_q + 1;
      // one servo pulse per cell while selected, none on a fault
      servo_q <= unit_select && !bad_lines && cell_q == 0;
   end
   // released bus shows inverse of last value
   always_comb begin
      drv.bus_in = tag_gate ? resp : ~last_q;
      drv.bus_in_par = ~^drv.bus_in;
      drv.drive_sel = bad_lines ? 6'h0F : 6'h07;
      drv.tag_valid = tag_gate && ^tag_out;
      drv.device_check = 1'b0;
      drv.servo_clk = servo_q;
   end
endmodule : dsa_drive_model
`default_nettype wire

//--- bench/dsa_top_tb.sv
// testbench: status assembler and orientation counter
`timescale 1ns/1ps
`default_nettype none
module dsa_top_tb
   import dsa_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, bp = 1'b0;
   logic clock_d = 1'b1, vfo_freq = 1'b0, vfo_phase = 1'b0, bad_lines = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, resp = 8'h00, rdata, bus_out;
   logic [3:0] tag_out;
   logic tag_gate, unit_sel, g_ref, g_data, hit, cmp_br;
   dsa_stat_s stat = '0;
   dsa_drv_s drv;
   int bad_count = 0, n_checks = 0;
   dsa_top dut_u (.CLK_SYS(clk), .SRST(srst), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .CLOCK_D(clock_d), .BYTE_PAIR(bp), .STAT(stat),
      .DRV(drv), .VFO_FREQ_ERR(vfo_freq), .VFO_PHASE_ERR(vfo_phase), .TAG_OUT(tag_out),
      .TAG_GATE(tag_gate), .BUS_OUT(bus_out), .UNIT_SELECT(unit_sel), .GATE_REF(g_ref),
      .GATE_DATA(g_data), .HIT(hit), .COMPARE_BRANCH(cmp_br));
   dsa_drive_model drv_u (.clk(clk), .tag_out(tag_out), .tag_gate(tag_gate),
      .bus_out(bus_out), .unit_select(unit_sel), .resp(resp), .bad_lines(bad_lines),
      .drv(drv), .rec_ready());
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(nm, {8'h00, e}, {8'h00, rdata});
   endtask : rd_chk
   task automatic sel_read(input logic [3:0] c, input logic [7:0] e);
      wr_reg(ADDR_INPUT_CTL, {c, 4'h0});
      repeat (6) @(posedge clk);
      rd_chk("status group", ADDR_STATUS_IN, e);
   endtask : sel_read
   task automatic rev(input int e);
      int n;
      logic h, b;
      n = 0;
      h = 1'b0;
      b = 1'b0;
      while (!h && n < 7000) begin
         @(posedge clk) bp <= 1'b1;
         #1 h = hit;
         b = b | cmp_br;
         @(posedge clk) bp <= 1'b0;
         #1 h = h | hit;
         b = b | cmp_br;
         n++;
      end
      chk("pairs to hit", 16'(e), 16'(n));
      chk("branch", 16'h1, {15'h0, b});
      // the loop sends one more pair after the wrap before it sees the hit
      rd_chk("count after hit", ADDR_ORIENT_LO, 8'h01);
   endtask : rev
   task automatic print_verdict;
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd_chk("input control", ADDR_INPUT_CTL, REG_RESET);
      rd_chk("file control", ADDR_FILE_CTL, REG_RESET);
      rd_chk("unmapped", 4'hF, 8'h00);
      chk("unit select", 16'h0, {15'h0, unit_sel});
   endtask : t_reset
   task automatic t_bus_in;
      resp <= 8'h5A;
      wr_reg(ADDR_INPUT_CTL, 8'h44);
      repeat (6) @(posedge clk);
      rd_chk("bus in", ADDR_STATUS_IN, 8'h5A);
      wr_reg(ADDR_STATUS_IN, 8'hFF);
      repeat (2) @(posedge clk);
      rd_chk("read only", ADDR_STATUS_IN, 8'h5A);
      clock_d <= 1'b0;
      resp <= 8'hA5;
      repeat (6) @(posedge clk);
      rd_chk("held without clock-D", ADDR_STATUS_IN, 8'h5A);
      clock_d <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk("load on clock-D", ADDR_STATUS_IN, 8'hA5);
   endtask : t_bus_in
   task automatic t_groups;
      stat.fault_address <= 12'hA5C;
      stat.phys_addr <= 1'b1;
      stat.log_addr <= 2'b10;
      stat.chan_sel <= 1'b1;
      stat.chan_disable_switch <= 2'b10;
      stat.data_sw <= 8'hC3;
      stat.switched_b <= 1'b1;
      stat.cassette <= 5'h15;
      sel_read(4'h0, 8'h70);
      sel_read(4'h1, 8'h29);
      sel_read(4'h2, 8'h1E);
      sel_read(4'h3, 8'h00);
      sel_read(4'hA, 8'h22);
      sel_read(4'hC, 8'hC3);
      sel_read(4'hD, 8'h20);
      sel_read(4'hE, 8'h00);
      sel_read(4'hF, 8'h15);
   endtask : t_groups
   task automatic t_file;
      wr_reg(ADDR_FILE_CTL, 8'hC3);
      @(posedge clk) #1;
      chk("sync gates", 16'h2, {14'h0, unit_sel, g_ref | g_data});
   endtask : t_file
   task automatic t_orient;
      wr_reg(ADDR_INPUT_CTL, 8'hC4);
      wr_reg(ADDR_BUS_OUT, 8'h80);
      rd_chk("preset lo", ADDR_ORIENT_LO, 8'h10);
      rd_chk("preset hi", ADDR_ORIENT_HI, 8'h00);
      repeat (5) begin
         @(posedge clk) bp <= 1'b1;
         @(posedge clk) bp <= 1'b0;
      end
      rd_chk("five pairs", ADDR_ORIENT_LO, 8'h15);
      wr_reg(ADDR_BUS_OUT, 8'h80);
      wr_reg(ADDR_FILE_CTL, 8'h83);
      @(posedge clk) #1;
      chk("lock gates", 16'h3, {14'h0, g_ref, g_data});
      rev(6705);
      rev(6720);
   endtask : t_orient
   // remaining status groups, servo loss and drive checks
   task automatic t_drive;
      stat.chan_err <= 5'h1F;
      stat.rw_err <= 6'h0F;
      stat.ecc_err <= 4'hF;
      stat.hard1 <= 7'h55;
      stat.hard2 <= 2'b11;
      stat.func_sw <= 4'h9;
      stat.single_cu <= 1'b1;
      stat.exec_rpt <= 1'b1;
      stat.ce_position <= 1'b1;
      vfo_freq <= 1'b1;
      vfo_phase <= 1'b1;
      sel_read(4'h4, 8'h3D);
      sel_read(4'h5, 8'hDE);
      sel_read(4'h6, 8'h0F);
      sel_read(4'h8, 8'h55);
      sel_read(4'h9, 8'h03);
      sel_read(4'hB, 8'h59);
      // bad position code and no servo pulses while selected
      bad_lines <= 1'b1;
      repeat (2100) @(posedge clk);
      sel_read(4'h5, 8'hFE);
      sel_read(4'h7, 8'h03);
   endtask : t_drive
   // ---------------------------------------------------------------
   // clock, watchdog, main sequence
   // ---------------------------------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #400000;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_bus_in();
      t_groups();
      t_file();
      t_orient();
      t_drive();
      print_verdict();
   end
endmodule : dsa_top_tb
`default_nettype wire
